// ---- shared/bam_defines.svh ----
/*
  Register offsets, control field positions, reset values and masks
  for the breakpoint address matcher.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BAM_DEFINES_SVH
`define BAM_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BAM_OFS_ADDR 4'h0
`define BAM_OFS_CTRL 4'h4
`define BAM_OFS_STAT 4'h8
`define BAM_OFS_MASK 4'hc
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BAM_CTRL_V 0
`define BAM_CTRL_AS_LO 1
`define BAM_CTRL_AS_HI 9
`define BAM_CTRL_MA_LO 10
`define BAM_CTRL_MA_HI 11
`define BAM_CTRL_NEG 12
`define BAM_CTRL_SIZ_LO 13
`define BAM_CTRL_SIZ_HI 14
`define BAM_CTRL_WIDTH_MASK_EN 15
`define BAM_CTRL_COMPARE_SOURCE_SEL 18
`define BAM_CTRL_WMASK 32'h0004_ffff
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define BAM_CTRL_RESET 32'h0000_0000
`define BAM_ADDR_RESET 32'h0000_0000
`define BAM_IRQ_RESET 32'h0000_0000
`define BAM_STAT_HIT 0
`define BAM_IRQ_WMASK 32'h0000_0001
`define BAM_BLK_2K 32'hffff_f800
`define BAM_BLK_8K 32'hffff_e000
`define BAM_BLK_32K 32'hffff_8000
`define BAM_BLK_ALL 32'hffff_ffff
`define BAM_RESP_OKAY 2'h0
`define BAM_RESP_SLVERR 2'h2
`endif

// ---- shared/bam_pkg.sv ----
/*
  Types of the breakpoint address matcher: the monitored bus cycle
  and the encodings of the block mask and access width fields.
  Assumes the defines header carries all numeric constants.
*/
package bam_pkg;
  // ----------------------------------------
  // Monitored bus cycle
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [1:0] width_code;
    logic [3:0] function_code;
    logic alt_encoding;
    logic [1:0] transfer_type;
    logic [2:0] transfer_modifier;
  } bam_cycle_t;
  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  typedef enum logic [1:0] {BAM_MA_FULL, BAM_MA_2K, BAM_MA_8K, BAM_MA_32K} bam_block_t;
  typedef enum logic [1:0] {BAM_SZ_LONG, BAM_SZ_BYTE, BAM_SZ_WORD, BAM_SZ_TRI} bam_width_t;
endpackage

// ---- verilog/bam_matcher.sv ----
/*
  Breakpoint address matcher with an AXI4-Lite register slave and a
  sticky, masked interrupt. Watches the internal or external bus.
  Assumes the internal bus is on aclk and the external bus is not.
*/
// Function
// - Size mask off, internal bus, block mask 00: address and width must both equal the programmed ones.
// - Exact width compare only with block mask 00; width codes long,byte,word,three.
// - Width masked, low 00: only access low 00; low 01: all but byte at 00.
// - Width masked, low 10: per overlap table, never at access low 11.
// - Width masked, low 11: per overlap table, any access at 11.
// - With block mask 00, no break unless the cycle touches the programmed byte; width masked low 01 also breaks at access low 10 or 11.
// - Invert match breaks outside the block; other qualifiers unchanged.
// - Invert match ignored when block mask is 00.
// - Block mask ignores address bits 10-0, 12-0 or 14-0.
// - Each set space bit suppresses breaks in that space; all clear ignores space.
// - Function code: bit 8 codes 1xxx, bit 7 code 0111, bit n code n.
// - Alternate encoding: bit 7 acknowledge type 11, bits 6-0 type 00 modifiers.
// - Break output stays low unless the valid bit is set.
// - Width masked, block mask 00: break when accessed bytes overlap the programmed address, and for low 01 on any access at 10 or 11.
// - Source select picks internal or external bus; external masks low bits.
`timescale 1ns/100ps
`include "bam_defines.svh"
module bam_matcher #(
  parameter int AXI_ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bam_pkg::bam_cycle_t internal_bus,
  input wire bam_pkg::bam_cycle_t external_bus,
  output logic break_request_out,
  output logic irq_out
);
  // ----------------------------------------
  // Parameter check and helpers
  // ----------------------------------------
  if (AXI_ADDR_W < 4 || AXI_ADDR_W > 32) begin : g_chk
    $error("AXI_ADDR_W must be 4 to 32");
  end
  function automatic logic is_reg(input logic [AXI_ADDR_W-1:0] a, input logic [3:0] ofs);
    return a == AXI_ADDR_W'(ofs);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // Overlap table: one bit per width code for programmed and access low bits
  function automatic logic [3:0] overlap(input logic [1:0] p, input logic [1:0] a);
    logic [3:0] r;
    r = 4'h0;
    unique case ({p, a})
      4'h0, 4'h5, 4'h6, 4'h7, 4'ha, 4'hf: r = 4'hf;
      4'h4, 4'h9, 4'he: r = 4'hd;
      4'h8, 4'hd: r = 4'h9;
      4'hc: r = 4'h1;
      default: r = 4'h0;
    endcase
    return r;
  endfunction
  // Address space of a cycle as one bit per space exclude bit
  function automatic logic [8:0] space_of(input bam_pkg::bam_cycle_t c);
    logic [8:0] r;
    r = 9'h000;
    if (c.alt_encoding) begin
      if (c.transfer_type == 2'h3) begin
        r[7] = 1'b1;
      end else if (c.transfer_type == 2'h0 && c.transfer_modifier != 3'h7) begin
        r[c.transfer_modifier] = 1'b1;
      end
    end else if (c.function_code[3]) begin
      r[8] = 1'b1;
    end else begin
      r[c.function_code[2:0]] = 1'b1;
    end
    return r;
  endfunction
  // ----------------------------------------
  // Registers and bus slave state
  // ----------------------------------------
  logic [31:0] break_address_reg, break_control_reg, status_reg, mask_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wdata_reg;
  logic [3:0] wstrb_reg, ovl_row;
  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic aw_have_reg, w_have_reg;
  logic aw_take, w_take, ar_take, wr_fire, wr_map, hit;
  logic break_out_reg, irq_reg;
  bam_pkg::bam_cycle_t ext_s1_reg, ext_s2_reg, sel_cyc;
  logic v_bit, neg, width_mask_en, compare_source_sel, excl, addr_in, addr_ok, low_match;
  logic [1:0] ma, siz;
  logic [8:0] as_bits;
  logic [31:0] blk_mask, stat_clr;
  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  assign ar_take = s_axi_arvalid && arready_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_map = is_reg(awaddr_reg, `BAM_OFS_ADDR) || is_reg(awaddr_reg, `BAM_OFS_CTRL)
               || is_reg(awaddr_reg, `BAM_OFS_STAT) || is_reg(awaddr_reg, `BAM_OFS_MASK);
  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `BAM_RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      awready_reg <= !aw_have_reg && !aw_take && !bvalid_reg;
      wready_reg <= !w_have_reg && !w_take && !bvalid_reg;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? `BAM_RESP_OKAY : `BAM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `BAM_RESP_OKAY;
    end else begin
      arready_reg <= !ar_take && !rvalid_reg;
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= `BAM_RESP_OKAY;
        if (is_reg(s_axi_araddr, `BAM_OFS_ADDR)) begin
          rdata_reg <= break_address_reg;
        end else if (is_reg(s_axi_araddr, `BAM_OFS_CTRL)) begin
          rdata_reg <= break_control_reg;
        end else if (is_reg(s_axi_araddr, `BAM_OFS_STAT)) begin
          rdata_reg <= status_reg;
        end else if (is_reg(s_axi_araddr, `BAM_OFS_MASK)) begin
          rdata_reg <= mask_reg;
        end else begin
          rdata_reg <= 32'h0;
          rresp_reg <= `BAM_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Match, status and interrupt registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_address_reg <= `BAM_ADDR_RESET;
      break_control_reg <= `BAM_CTRL_RESET;
      mask_reg <= `BAM_IRQ_RESET;
    end else if (wr_fire) begin
      if (is_reg(awaddr_reg, `BAM_OFS_ADDR)) begin
        break_address_reg <= merge(break_address_reg, wdata_reg, wstrb_reg);
      end
      if (is_reg(awaddr_reg, `BAM_OFS_CTRL)) begin
        break_control_reg <= merge(break_control_reg, wdata_reg, wstrb_reg) & `BAM_CTRL_WMASK;
      end
      if (is_reg(awaddr_reg, `BAM_OFS_MASK)) begin
        mask_reg <= merge(mask_reg, wdata_reg, wstrb_reg) & `BAM_IRQ_WMASK;
      end
    end
  end
  assign stat_clr = (wr_fire && is_reg(awaddr_reg, `BAM_OFS_STAT)) ?
                    merge(32'h0, wdata_reg, wstrb_reg) : 32'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= `BAM_IRQ_RESET;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= ((status_reg & ~stat_clr) | {31'h0, hit}) & `BAM_IRQ_WMASK;
      irq_reg <= |(status_reg & mask_reg);
    end
  end
  // ----------------------------------------
  // External bus synchroniser
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
    end else begin
      ext_s1_reg <= external_bus;
      ext_s2_reg <= ext_s1_reg;
    end
  end
  // ----------------------------------------
  // Match decision
  // ----------------------------------------
  assign v_bit = break_control_reg[`BAM_CTRL_V];
  assign as_bits = break_control_reg[`BAM_CTRL_AS_HI:`BAM_CTRL_AS_LO];
  assign ma = break_control_reg[`BAM_CTRL_MA_HI:`BAM_CTRL_MA_LO];
  assign neg = break_control_reg[`BAM_CTRL_NEG];
  assign siz = break_control_reg[`BAM_CTRL_SIZ_HI:`BAM_CTRL_SIZ_LO];
  assign width_mask_en = break_control_reg[`BAM_CTRL_WIDTH_MASK_EN];
  assign compare_source_sel = break_control_reg[`BAM_CTRL_COMPARE_SOURCE_SEL];
  always_comb begin
    sel_cyc = compare_source_sel ? ext_s2_reg : internal_bus;
    unique case (bam_pkg::bam_block_t'(ma))
      bam_pkg::BAM_MA_2K: blk_mask = `BAM_BLK_2K;
      bam_pkg::BAM_MA_8K: blk_mask = `BAM_BLK_8K;
      bam_pkg::BAM_MA_32K: blk_mask = `BAM_BLK_32K;
      default: blk_mask = `BAM_BLK_ALL;
    endcase
    // overlap on low bits, table, programmed byte touched, or programmed low 01 with access low 10 or 11
    ovl_row = overlap(break_address_reg[1:0], sel_cyc.addr[1:0]);
    low_match = ovl_row[sel_cyc.width_code];
    if (ma != 2'h0) begin
      addr_in = (sel_cyc.addr & blk_mask) == (break_address_reg & blk_mask);
    end else if (width_mask_en || compare_source_sel) begin
      addr_in = (sel_cyc.addr[31:2] == break_address_reg[31:2]) && low_match;
    end else begin
      addr_in = (sel_cyc.addr == break_address_reg) && (sel_cyc.width_code == siz);
    end
    // invert only with a block selected
    addr_ok = (ma != 2'h0 && neg) ? !addr_in : addr_in;
    excl = |(space_of(sel_cyc) & as_bits);
    hit = v_bit && sel_cyc.valid && addr_ok && !excl;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_out_reg <= 1'b0;
    end else begin
      break_out_reg <= hit;
    end
  end
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign break_request_out = break_out_reg;
  assign irq_out = irq_reg;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  valid_gate_a:
    assert property (!v_bit |=> !break_out_reg) else $error("break while not valid");
  exact_hit_a:
    assert property (v_bit && sel_cyc.valid && ma == 2'h0 && !width_mask_en && !compare_source_sel && !excl
      && sel_cyc.addr == break_address_reg && sel_cyc.width_code == siz |=> break_out_reg)
      else $error("exact match missed");
  size_cmp_a:
    assert property (ma == 2'h0 && !width_mask_en && !compare_source_sel && sel_cyc.width_code != siz
      |=> !break_out_reg) else $error("break on width mismatch");
  block_cmp_a:
    assert property (ma == 2'h1 && !neg && sel_cyc.addr[31:11] != break_address_reg[31:11]
      |=> !break_out_reg) else $error("break outside 2K block");
  invert_blk_a:
    assert property (ma != 2'h0 && neg
      && (sel_cyc.addr & blk_mask) == (break_address_reg & blk_mask)
      |=> !break_out_reg) else $error("inverted break inside block");
  neg_ignore_a:
    assert property (ma == 2'h0 && neg && sel_cyc.addr[31:2] != break_address_reg[31:2]
      |=> !break_out_reg) else $error("invert applied with no block");
  fc_dma_a:
    assert property (!sel_cyc.alt_encoding && sel_cyc.function_code[3] && as_bits[8]
      |=> !break_out_reg) else $error("break in excluded space");
  tt_ack_a:
    assert property (sel_cyc.alt_encoding && sel_cyc.transfer_type == 2'h3 && as_bits[7]
      |=> !break_out_reg) else $error("break on excluded acknowledge");
  ovl_zero_a:
    assert property (ma == 2'h0 && (width_mask_en || compare_source_sel) && break_address_reg[1:0] == 2'h0
      && sel_cyc.addr[1:0] != 2'h0 |=> !break_out_reg) else $error("overlap low 00 wrong");
  ovl_two_a:
    assert property (ma == 2'h0 && (width_mask_en || compare_source_sel) && break_address_reg[1:0] == 2'h2
      && sel_cyc.addr[1:0] == 2'h3 |=> !break_out_reg) else $error("overlap low 10 wrong");
  one_cycle_a:
    assert property (break_out_reg |-> $past(hit) ##1 (irq_reg || !$past(mask_reg[0])))
      else $error("break without matching cycle");
  exact_hit_c: cover property (ma == 2'h0 && !width_mask_en && hit ##1 break_out_reg);
  invert_hit_c: cover property (ma != 2'h0 && neg && hit ##1 break_out_reg);
  ext_hit_c: cover property (compare_source_sel && hit ##1 break_out_reg ##1 irq_reg);
endmodule

// ---- test/bam_bus_model.sv ----
/*
  Bus master model for the monitored internal and external buses.
  Assumes the bench raises go, ext and cyc just after a rising edge.
*/
`timescale 1ns/100ps
module bam_bus_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic ext,
  input wire bam_pkg::bam_cycle_t cyc,
  output bam_pkg::bam_cycle_t internal_bus,
  output bam_pkg::bam_cycle_t external_bus
);
  bam_pkg::bam_cycle_t ib = '0;
  bam_pkg::bam_cycle_t xb = '0;
  // Idle bus shows the inverse of its last value, so stale fields never match
  function automatic bam_pkg::bam_cycle_t idle(input bam_pkg::bam_cycle_t c);
    bam_pkg::bam_cycle_t r;
    r = ~c;
    r.valid = 1'b0;
    return r;
  endfunction
  always_ff @(posedge aclk) begin
    ib <= (go && !ext) ? cyc : idle(ib);
  end
  always_ff @(posedge aclk) begin
    xb <= (go && ext) ? cyc : idle(xb);
  end
  assign internal_bus = ib;
  assign external_bus = xb;
endmodule

// ---- test/bam_matcher_bench.sv ----
/*
  Self-checking bench for the breakpoint address matcher.
  Assumes the AXI4-Lite slave and the bus model in test/.
*/
`timescale 1ns/100ps
`include "bam_defines.svh"
module bam_matcher_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = '0;
  logic [4:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, brk, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic go = 1'b0, ext = 1'b0;
  bam_pkg::bam_cycle_t cyc = '0;
  bam_pkg::bam_cycle_t ibus, xbus;
  logic [31:0] cur_addr = '0, cur_ctrl = '0;
  int bad_count = 0;
  int tests_run = 0;
  always #5 aclk = ~aclk;
  bam_matcher #(.AXI_ADDR_W(5)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .internal_bus(ibus), .external_bus(xbus), .break_request_out(brk), .irq_out(irq));
  bam_bus_model model (.aclk(aclk), .go(go), .ext(ext), .cyc(cyc),
    .internal_bus(ibus), .external_bus(xbus));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic pa, pw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    while (bvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    if (n >= 100) bad_count++;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic pa;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    n = 0;
    while (rvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
      if (pa && arready === 1'b1) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    if (n >= 100) bad_count++;
  endtask
  function automatic logic [31:0] ctl(input logic v, input logic [8:0] x, input logic [1:0] ma,
      input logic g, input logic [1:0] s, input logic z, input logic b);
    return {13'h0, b, 2'h0, z, s, g, ma, x, v};
  endfunction
  task automatic setup(input logic [31:0] a, input logic [31:0] c);
    wr(`BAM_OFS_ADDR, a, `BAM_RESP_OKAY);
    wr(`BAM_OFS_CTRL, c, `BAM_RESP_OKAY);
    cur_addr = a;
    cur_ctrl = c;
  endtask
  function automatic bam_pkg::bam_cycle_t mk(input logic [31:0] ad, input logic [1:0] w,
      input logic [3:0] fc, input logic al, input logic [1:0] tt, input logic [2:0] tm);
    bam_pkg::bam_cycle_t r;
    r = {1'b1, ad, w, fc, al, tt, tm};
    return r;
  endfunction
  // Expected break from the programmed address and control values
  function automatic logic ref_hit(input bam_pkg::bam_cycle_t c, input logic x);
    logic [31:0] m;
    logic [15:0] tb;
    int sp;
    if (!cur_ctrl[0]) return 1'b0;
    // Only the bus picked by the source select can break
    if (x != cur_ctrl[18]) return 1'b0;
    sp = -1;
    if (!c.alt_encoding) sp = c.function_code[3] ? 8 : int'(c.function_code);
    else if (c.transfer_type == 2'h3) sp = 7;
    else if (c.transfer_type == 2'h0 && c.transfer_modifier != 3'h7) sp = int'(c.transfer_modifier);
    if (sp >= 0 && cur_ctrl[1+sp]) return 1'b0;
    case (cur_ctrl[11:10])
      2'h1: m = 32'hffff_f800;
      2'h2: m = 32'hffff_e000;
      default: m = 32'hffff_8000;
    endcase
    if (cur_ctrl[11:10] != 2'h0) return ((c.addr & m) == (cur_addr & m)) ^ cur_ctrl[12];
    case (cur_addr[1:0])
      2'h0: tb = 16'h000f;
      2'h1: tb = 16'hfffd;
      2'h2: tb = 16'h0fd9;
      default: tb = 16'hfd91;
    endcase
    if (x || cur_ctrl[15]) return c.addr[31:2] == cur_addr[31:2] && tb[{c.addr[1:0], c.width_code}];
    return c.addr == cur_addr && c.width_code == cur_ctrl[14:13];
  endfunction
  // Drive k back-to-back cycles and count the clock cycles with the break output high that follow
  task automatic probe(input bam_pkg::bam_cycle_t c, input logic x, input int k, input string nm);
    int hits;
    @(posedge aclk);
    cyc <= c;
    ext <= x;
    go <= 1'b1;
    hits = 0;
    for (int i = 0; i < k + 8; i++) begin
      @(posedge aclk);
      if (i == k - 1) go <= 1'b0;
      #1;
      if (brk === 1'b1) hits++;
    end
    chk(nm, ref_hit(c, x) ? k : 0, hits);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] b;
    b = 32'h1234_5678;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`BAM_OFS_ADDR, 32'h0, `BAM_RESP_OKAY);
    rd(`BAM_OFS_CTRL, 32'h0, `BAM_RESP_OKAY);
    rd(`BAM_OFS_STAT, 32'h0, `BAM_RESP_OKAY);
    rd(`BAM_OFS_MASK, 32'h0, `BAM_RESP_OKAY);
    chk("irq_out", 32'h0, {31'h0, irq});
    wr(`BAM_OFS_CTRL, 32'hffff_ffff, `BAM_RESP_OKAY);
    rd(`BAM_OFS_CTRL, 32'h0004_ffff, `BAM_RESP_OKAY);
    wr(5'h10, 32'hffff_ffff, `BAM_RESP_SLVERR);
    rd(5'h10, 32'h0, `BAM_RESP_SLVERR);
    $display("test registers done");
    setup(32'h1000_0002, ctl(1'b0, 9'h0, 2'h0, 1'b0, 2'h2, 1'b0, 1'b0));
    probe(mk(32'h1000_0002, 2'h2, 4'h1, 1'b0, 2'h0, 3'h0), 1'b0, 1, "valid_off");
    setup(32'h1000_0002, ctl(1'b1, 9'h0, 2'h0, 1'b0, 2'h2, 1'b0, 1'b0));
    for (int a = 0; a < 4; a++) for (int s = 0; s < 4; s++) begin
      probe(mk({cur_addr[31:2], 2'(a)}, 2'(s), 4'h1, 1'b0, 2'h0, 3'h0), 1'b0, 1, "exact");
    end
    $display("test exact done");
    for (int m = 0; m < 2; m++) for (int p = 0; p < 4; p++) begin
      setup(32'h2000_0000 | p, ctl(1'b1, 9'h0, 2'h0, 1'b0, 2'h0, 1'(1 - m), 1'(m)));
      probe(mk(cur_addr ^ 32'h4, 2'h0, 4'h1, 1'b0, 2'h0, 3'h0), 1'(m), 1, "far");
      for (int a = 0; a < 4; a++) for (int s = 0; s < 4; s++) begin
        probe(mk({cur_addr[31:2], 2'(a)}, 2'(s), 4'h1, 1'b0, 2'h0, 3'h0), 1'(m), 1,
          "overlap");
      end
    end
    $display("test overlap done");
    for (int m = 0; m < 4; m++) for (int g = 0; g < 2; g++) begin
      setup(b, ctl(1'b1, 9'h0, 2'(m), 1'(g), 2'h0, 1'b0, 1'b0));
      for (int i = 0; i < 7; i++) begin
        probe(mk(i < 6 ? b ^ (32'h1 << (i + 10)) : b, 2'h0, 4'h1, 1'b0, 2'h0, 3'h0), 1'b0, 1,
          "block");
      end
    end
    $display("test block done");
    for (int n = 0; n < 10; n++) begin
      setup(b, ctl(1'b1, n < 9 ? 9'(1 << n) : 9'h0, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0));
      for (int i = 0; i < 16; i++) begin
        probe(mk(b, 2'h0, 4'(i), 1'b0, 2'h0, 3'h0), 1'b0, 1, "space_fc");
      end
      for (int i = 0; i < 11; i++) begin
        probe(mk(b, 2'h0, 4'h0, 1'b1, i < 8 ? 2'h0 : 2'(i - 7), i < 8 ? 3'(i) : 3'h0), 1'b0, 1,
          "space_tt");
      end
    end
    $display("test space done");
    wr(`BAM_OFS_STAT, 32'h1, `BAM_RESP_OKAY);
    rd(`BAM_OFS_STAT, 32'h0, `BAM_RESP_OKAY);
    wr(`BAM_OFS_MASK, 32'h1, `BAM_RESP_OKAY);
    chk("irq_out", 32'h0, {31'h0, irq});
    probe(mk(b, 2'h0, 4'h1, 1'b0, 2'h0, 3'h0), 1'b0, 2, "burst_int");
    setup(b, ctl(1'b1, 9'h0, 2'h0, 1'b0, 2'h0, 1'b0, 1'b1));
    probe(mk(b, 2'h0, 4'h1, 1'b0, 2'h0, 3'h0), 1'b1, 3, "burst_ext");
    probe(mk(b, 2'h0, 4'h1, 1'b0, 2'h0, 3'h0), 1'b0, 1, "wrong_bus");
    chk("irq_out", 32'h1, {31'h0, irq});
    rd(`BAM_OFS_STAT, 32'h1, `BAM_RESP_OKAY);
    wr(`BAM_OFS_STAT, 32'h1, `BAM_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq_out", 32'h0, {31'h0, irq});
    wr(`BAM_OFS_MASK, 32'h0, `BAM_RESP_OKAY);
    probe(mk(b, 2'h0, 4'h1, 1'b0, 2'h0, 3'h0), 1'b1, 1, "masked_hit");
    chk("irq_out", 32'h0, {31'h0, irq});
    rd(`BAM_OFS_STAT, 32'h1, `BAM_RESP_OKAY);
    $display("test interrupt done");
    tally_and_finish();
  end
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
endmodule
